//--- hw/fifo_parallel_printer_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pport_defines.svh"

module fifo_parallel_printer_port
  import pport_pkg::*;
#(
  parameter int FIFO_DEPTH = 128
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reset_pin,
  input  wire logic       bus_mode,
  input  wire logic       host_cs_n,
  input  wire logic [2:0] host_addr,
  input  wire logic       host_write_strobe_n,
  input  wire logic       host_read_strobe_n,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n,
  output logic            data_taken_out,
  input  wire logic [7:0] periph_data_lines_in,
  output logic      [7:0] periph_data_lines_out,
  output logic            periph_data_lines_oe_n,
  input  wire logic       error_input,
  input  wire logic       periph_selected_input,
  input  wire logic       paper_out_input,
  input  wire logic       ack_input,
  input  wire logic       busy_input,
  input  wire logic       data_valid_in,
  output logic            data_valid_out,
  output logic            data_valid_oe_n,
  input  wire logic       line_feed_request_in,
  output logic            line_feed_request_out,
  output logic            line_feed_request_oe_n,
  input  wire logic       restart_in,
  output logic            restart_out,
  output logic            restart_oe_n,
  input  wire logic       periph_choose_in,
  output logic            periph_choose_out,
  output logic            periph_choose_oe_n,
  output logic            interrupt_out,
  output logic            interrupt_oe_n
);

  localparam int PW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth
    $error("FIFO_DEPTH must be a power of two from 2 to 128");
  end

  // ---------------------------------------------------------------
  // Host bus decode
  // ---------------------------------------------------------------
  logic       sreset;
  logic       rd_level;
  logic       wr_level;
  logic       rd_prev_reg;
  logic       wr_prev_reg;
  logic       rd_start;
  logic       wr_start;
  logic [7:0] pin_ctrl_reg;
  logic [7:0] setup_reg;
  logic [7:0] trigger_reg;
  logic [7:0] out_latch_reg;
  logic       no_pending_reg;
  logic       ack_prev_reg;
  logic       ack_fall;
  logic       started_reg;
  logic       fifo_en;
  logic       dir_input;
  logic       fifo_clear;

  // Reset pin polarity follows the bus style
  assign sreset = bus_mode ? reset_pin : ~reset_pin;

  // Strobe style: separate strobes; direction style: read/write line plus data strobe
  always_comb begin
    if (bus_mode) begin
      rd_level = ~host_cs_n && ~host_read_strobe_n;
      wr_level = ~host_cs_n && ~host_write_strobe_n;
    end else begin
      rd_level = ~host_cs_n && ~host_read_strobe_n && host_write_strobe_n;
      wr_level = ~host_cs_n && ~host_read_strobe_n && ~host_write_strobe_n;
    end
  end

  assign rd_start = rd_level && !rd_prev_reg;
  assign wr_start = wr_level && !wr_prev_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_level;
      wr_prev_reg <= wr_level;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  assign fifo_en   = setup_reg[`SET_FIFO_EN_BIT];
  assign dir_input = pin_ctrl_reg[`CTL_DIR_BIT];
  // Restart low empties the FIFO and rearms the auto start
  assign fifo_clear = sreset || !pin_ctrl_reg[`CTL_RESTART_BIT] || !fifo_en;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_ctrl_reg <= `PIN_CTRL_RESET;
      setup_reg    <= `SETUP_RESET;
      trigger_reg  <= `TRIGGER_RESET;
    end else if (sreset) begin
      pin_ctrl_reg <= `PIN_CTRL_RESET;
      setup_reg    <= `SETUP_RESET;
      trigger_reg  <= `TRIGGER_RESET;
    end else if (wr_start) begin
      unique case (host_addr)
        `ADDR_PIN_CTRL: pin_ctrl_reg <= {2'b00, host_data_in[5:0]};
        `ADDR_SETUP:    setup_reg    <= host_data_in;
        `ADDR_TRIGGER:  trigger_reg  <= host_data_in;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Acknowledge edge and interrupt condition
  // ---------------------------------------------------------------
  assign ack_fall = ack_prev_reg && !ack_input;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_prev_reg <= 1'b1;
    end else begin
      ack_prev_reg <= ack_input;
    end
  end

  // Edge wins over a status read in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      no_pending_reg <= 1'b1;
    end else if (sreset) begin
      no_pending_reg <= 1'b1;
    end else if (ack_fall) begin
      no_pending_reg <= 1'b0;
    end else if (rd_start && host_addr == `ADDR_STATUS) begin
      no_pending_reg <= 1'b1;
    end
  end

  // Auto transfer waits for the peripheral's first acknowledge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      started_reg <= 1'b0;
    end else if (fifo_clear) begin
      started_reg <= 1'b0;
    end else if (ack_fall) begin
      started_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // FIFO storage
  // ---------------------------------------------------------------
  logic [7:0]  fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   count_reg;
  logic        fifo_full;
  logic        fifo_empty;
  logic        push;
  logic        pop;
  logic [7:0]  push_data;
  logic [7:0]  head_data;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [7:0]  buf_out_data;

  assign fifo_full  = (count_reg == (PW+1)'(FIFO_DEPTH));
  assign fifo_empty = (count_reg == '0);
  assign head_data  = fifo_mem[rd_ptr_reg];

  // Direction decides who fills and who drains
  always_comb begin
    if (dir_input) begin
      push      = fifo_en && ack_fall && !fifo_full;
      push_data = periph_data_lines_in;
      pop       = rd_start && host_addr == `ADDR_PORT_DATA && !fifo_empty;
    end else begin
      push      = fifo_en && wr_start && host_addr == `ADDR_PORT_DATA && !fifo_full;
      push_data = host_data_in;
      pop       = started_reg && buf_in_ready && !fifo_empty;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (fifo_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // Holds bytes already leaving the FIFO while the engine stalls
  two_entry_buffer #(
    .WIDTH (8)
  ) u_out_buffer (
    .mclk      (mclk),
    .rst       (rst),
    .clear     (fifo_clear || dir_input),
    .in_valid  (pop && !dir_input),
    .in_ready  (buf_in_ready),
    .in_data   (head_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ---------------------------------------------------------------
  // Data-valid pulse engine
  // ---------------------------------------------------------------
  engine_state_t state_reg;
  logic [7:0]    timer_reg;
  logic [7:0]    width_cyc;

  always_comb begin
    unique case (setup_reg[4:3])
      2'b00: width_cyc = 8'(`WIDTH0_CYC);
      2'b01: width_cyc = 8'(`WIDTH1_CYC);
      2'b10: width_cyc = 8'(`WIDTH2_CYC);
      2'b11: width_cyc = 8'(`WIDTH3_CYC);
    endcase
  end

  // Busy low means the peripheral can take the next byte
  assign buf_out_ready = (state_reg == ENG_IDLE) && !busy_input && !dir_input;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ENG_IDLE;
      timer_reg <= 8'h00;
    end else if (fifo_clear || dir_input) begin
      state_reg <= ENG_IDLE;
      timer_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ENG_IDLE: begin
          if (buf_out_valid && buf_out_ready) begin
            state_reg <= ENG_SETUP;
            timer_reg <= 8'(`SETUP_CYC);
          end
        end
        ENG_SETUP: begin
          if (timer_reg == 8'h01) begin
            state_reg <= ENG_PULSE;
            timer_reg <= width_cyc;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ENG_PULSE: begin
          if (timer_reg == 8'h01) begin
            state_reg <= ENG_WAIT;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ENG_WAIT: begin
          // Next byte only after the peripheral acknowledges this one
          if (ack_fall) begin
            state_reg <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // Output latch: direct writes without FIFO, engine bytes with it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_latch_reg <= 8'h00;
    end else if (sreset) begin
      out_latch_reg <= 8'h00;
    end else if (state_reg == ENG_IDLE && buf_out_valid && buf_out_ready) begin
      out_latch_reg <= buf_out_data;
    end else if (!fifo_en && !dir_input && wr_start && host_addr == `ADDR_PORT_DATA) begin
      out_latch_reg <= host_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral pins
  // ---------------------------------------------------------------
  logic strobe_low;
  logic irq_cond;
  logic irq_level;

  assign strobe_low = pin_ctrl_reg[`CTL_STROBE_BIT] || (state_reg == ENG_PULSE);

  always_comb begin
    unique case (irq_source_t'(setup_reg[2:1]))
      SRC_ACK:     irq_cond = !no_pending_reg;
      SRC_EMPTY:   irq_cond = fifo_en && fifo_empty;
      SRC_TRIGGER: irq_cond = fifo_en && 8'(count_reg) >= trigger_reg;
      SRC_FULL:    irq_cond = fifo_en && fifo_full;
    endcase
  end

  // Polarity bit flips the asserted level
  assign irq_level = setup_reg[`SET_POLARITY_BIT] ? irq_cond : !irq_cond;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periph_data_lines_out  <= 8'h00;
      periph_data_lines_oe_n <= 1'b0;
      data_valid_oe_n        <= 1'b1;
      line_feed_request_oe_n <= 1'b1;
      restart_oe_n           <= 1'b0;
      periph_choose_oe_n     <= 1'b1;
      interrupt_out          <= 1'b0;
      interrupt_oe_n         <= 1'b1;
    end else begin
      periph_data_lines_out  <= out_latch_reg;
      periph_data_lines_oe_n <= dir_input;
      data_valid_oe_n        <= !strobe_low;
      line_feed_request_oe_n <= !pin_ctrl_reg[`CTL_LINEFEED_BIT];
      restart_oe_n           <= pin_ctrl_reg[`CTL_RESTART_BIT];
      periph_choose_oe_n     <= !pin_ctrl_reg[`CTL_CHOOSE_BIT];
      interrupt_out          <= irq_level;
      interrupt_oe_n         <= !pin_ctrl_reg[`CTL_IRQ_EN_BIT];
    end
  end

  // Open-drain pins only ever pull low
  assign data_valid_out        = 1'b0;
  assign line_feed_request_out = 1'b0;
  assign restart_out           = 1'b0;
  assign periph_choose_out     = 1'b0;

  // ---------------------------------------------------------------
  // Read mux and bus answer
  // ---------------------------------------------------------------
  logic [7:0] read_value;
  logic [7:0] port_value;

  always_comb begin
    if (!dir_input) begin
      port_value = out_latch_reg;
    end else if (fifo_en) begin
      port_value = fifo_empty ? 8'h00 : head_data;
    end else begin
      port_value = periph_data_lines_in;
    end
  end

  always_comb begin
    unique case (host_addr)
      `ADDR_PORT_DATA: read_value = port_value;
      `ADDR_STATUS: read_value = {!busy_input, ack_input, paper_out_input,
                                  periph_selected_input, error_input,
                                  no_pending_reg, 2'b11};
      // Pins are read back, so a peripheral holding a line low shows up
      `ADDR_PIN_CTRL: read_value = {3'b111, pin_ctrl_reg[`CTL_IRQ_EN_BIT],
                                    !periph_choose_in, restart_in,
                                    !line_feed_request_in, !data_valid_in};
      `ADDR_SETUP:     read_value = setup_reg;
      `ADDR_TRIGGER:   read_value = trigger_reg;
      `ADDR_FIFO_STAT: read_value = {7'(count_reg), fifo_en};
      default:         read_value = 8'hFF;
    endcase
  end

  // Data is captured once, at the start of the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_data_out  <= 8'h00;
      host_data_oe_n <= 1'b1;
      data_taken_out <= 1'b1;
    end else begin
      if (rd_start) begin
        host_data_out <= read_value;
      end
      host_data_oe_n <= !rd_level;
      data_taken_out <= !(rd_level || wr_level);
    end
  end

endmodule // fifo_parallel_printer_port

`default_nettype wire

//--- hw/pport_defines.svh
// Function
// - Port data write drives lines in output mode; read in input mode gives line levels
// - Data lines come out of reset in output mode
// - Status bit 2 goes to 0 on every acknowledge falling edge
// - Status read returns bit 2 to 1; bits 1 and 0 read 1
// - Status bits 3-6 mirror error, selected, paper-out, ack; bit 7 is busy low
// - Readback bits 0,1,3 are 1 for low pin; bit 2 is 1 for high restart pin
// - Readback bit 4 is interrupt enable; bits 7-5 read 1
// - Control bits 0,1,3 drive their pins low; bit 2 at 1 releases restart, at 0 drives it low
// - Control bit 4 enables interrupt pin drive, else three-state
// - Control bit 5 picks data direction, 1 for input; bits 7-6 unused
// - Setup bit 0 enables the 128-byte FIFO, disabled by default
// - Setup bits 2-1 pick interrupt source: ack, empty, trigger level, full
// - Setup bits 4-3 pick one of four data-valid pulse widths
// - FIFO is cleared on reset and while restart is driven low
// - Automatic transfer starts after first acknowledge, paced by the peripheral
// - FIFO serves whichever direction is selected
// - Bus style pin: high separate strobes, low direction line plus strobe
// - Reset pin active high in strobe style, active low in direction style
// - Data-taken output goes low once the device accepts an access
// - Device drives addressed register onto host bus during read strobe
// - Interrupt pin three-state when disabled, polarity chosen by setup bit 7
// - Setup bit 7 at 0 gives active low interrupt, 1 active high
`ifndef PPORT_DEFINES_SVH
`define PPORT_DEFINES_SVH

`define ADDR_PORT_DATA      3'h0
`define ADDR_STATUS         3'h1
`define ADDR_PIN_CTRL       3'h2
`define ADDR_SETUP          3'h3
`define ADDR_TRIGGER        3'h4
`define ADDR_FIFO_STAT      3'h5

`define CTL_STROBE_BIT      0
`define CTL_LINEFEED_BIT    1
`define CTL_RESTART_BIT     2
`define CTL_CHOOSE_BIT      3
`define CTL_IRQ_EN_BIT      4
`define CTL_DIR_BIT         5

`define SET_FIFO_EN_BIT     0
`define SET_POLARITY_BIT    7

`define PIN_CTRL_RESET      8'h00
`define SETUP_RESET         8'h00
`define TRIGGER_RESET       8'h40

`define CLK_PERIOD_NS       100
`define WIDTH0_NS           1000
`define WIDTH1_NS           2000
`define WIDTH2_NS           5000
`define WIDTH3_NS           10000
`define WIDTH0_CYC          ((`WIDTH0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH1_CYC          ((`WIDTH1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH2_CYC          ((`WIDTH2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH3_CYC          ((`WIDTH3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC           1

`endif

//--- hw/pport_pkg.sv
package pport_pkg;

  typedef enum logic [3:0] {
    ENG_IDLE  = 4'b0001,
    ENG_SETUP = 4'b0010,
    ENG_PULSE = 4'b0100,
    ENG_WAIT  = 4'b1000
  } engine_state_t;

  typedef enum logic [1:0] {
    SRC_ACK     = 2'b00,
    SRC_EMPTY   = 2'b01,
    SRC_TRIGGER = 2'b10,
    SRC_FULL    = 2'b11
  } irq_source_t;

endpackage

//--- hw/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot_reg [2];
  logic             rd_ptr_reg;
  logic             wr_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("two_entry_buffer: WIDTH must be positive");
  end

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = slot_reg[rd_ptr_reg];

  always_ff @(posedge mclk) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else if (clear) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

//--- dv/fifo_parallel_printer_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_parallel_printer_port_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       bus_mode,
  input wire logic       host_cs_n,
  input wire logic [2:0] host_addr,
  input wire logic       host_write_strobe_n,
  input wire logic       host_read_strobe_n,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  input wire logic       data_taken_out,
  input wire logic [7:0] periph_data_lines_out,
  input wire logic       periph_data_lines_oe_n,
  input wire logic       data_valid_oe_n,
  input wire logic       line_feed_request_oe_n,
  input wire logic       restart_oe_n,
  input wire logic       periph_choose_oe_n,
  input wire logic       interrupt_oe_n
);
  wire logic wr = !host_cs_n && (bus_mode ? !host_write_strobe_n
                  : (!host_read_strobe_n && !host_write_strobe_n));
  wire logic rd = !host_cs_n && (bus_mode ? !host_read_strobe_n
                  : (!host_read_strobe_n && host_write_strobe_n));
  wire logic acc = wr || rd;
  logic [7:0] ctl_q;

  // Byte of the last write, held for the delayed pin checks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ctl_q <= 8'h00;
    else if ($rose(wr)) ctl_q <= host_data_in;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  read_drive_a: assert property ($rose(rd) |=> !host_data_oe_n && !data_taken_out)
    else $error("read not answered");
  write_taken_a: assert property ($rose(wr) |=> !data_taken_out && host_data_oe_n)
    else $error("write not taken");
  access_end_a: assert property ($fell(acc) |=> data_taken_out && host_data_oe_n)
    else $error("access not released");
  bus_quiet_a: assert property (!rd && !$past(rd) |-> host_data_oe_n)
    else $error("bus driven outside read");
  status_ones_a: assert property ($rose(rd) && host_addr == 3'h1 |=> host_data_out[1:0] == 2'h3)
    else $error("status low bits not one");
  readback_ones_a: assert property ($rose(rd) && host_addr == 3'h2 |=> host_data_out[7:5] == 3'h7)
    else $error("readback high bits not one");
  pin_ctrl_a: assert property ($rose(wr) && host_addr == 3'h2 |-> ##3
    line_feed_request_oe_n == !ctl_q[1] && restart_oe_n == ctl_q[2] && periph_choose_oe_n == !ctl_q[3])
    else $error("control pins wrong");
  irq_gate_a: assert property ($rose(wr) && host_addr == 3'h2 |-> ##3 interrupt_oe_n == !ctl_q[4])
    else $error("interrupt enable wrong");
  direction_a: assert property ($rose(wr) && host_addr == 3'h2 |-> ##3 periph_data_lines_oe_n == ctl_q[5])
    else $error("direction wrong");
  strobe_min_a: assert property ($fell(data_valid_oe_n) |=> !data_valid_oe_n [*8])
    else $error("data valid pulse short");
  lines_hold_a: assert property (!data_valid_oe_n && !$past(data_valid_oe_n) |-> $stable(periph_data_lines_out))
    else $error("data moved during pulse");

  cover property ($fell(data_valid_oe_n));
  cover property ($rose(rd) && host_addr == 3'h1);
  cover property ($rose(wr) && host_addr == 3'h0);
  cover property (!interrupt_oe_n);
endmodule // fifo_parallel_printer_port_props

bind fifo_parallel_printer_port fifo_parallel_printer_port_props u_props (
  .mclk(mclk), .rst(rst), .bus_mode(bus_mode), .host_cs_n(host_cs_n), .host_addr(host_addr),
  .host_write_strobe_n(host_write_strobe_n), .host_read_strobe_n(host_read_strobe_n),
  .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
  .data_taken_out(data_taken_out), .periph_data_lines_out(periph_data_lines_out),
  .periph_data_lines_oe_n(periph_data_lines_oe_n), .data_valid_oe_n(data_valid_oe_n),
  .line_feed_request_oe_n(line_feed_request_oe_n), .restart_oe_n(restart_oe_n),
  .periph_choose_oe_n(periph_choose_oe_n), .interrupt_oe_n(interrupt_oe_n));
`default_nettype wire

//--- dv/pport_printer_model.sv
`timescale 1ns/1ps
`default_nettype none
module pport_printer_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       dv_pin,
  input  wire logic [7:0] pd_pin,
  input  wire logic       kick,
  output logic            ack_n,
  output logic            busy,
  output logic      [7:0] pd_drv
);
  logic [7:0] got[$];
  int         lo_cnt;
  int         last_w;
  int         dly;

  // ------------------------------------------------------------
  // Slow printer: busy through the pulse, ack well after it ends
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_n <= 1'h1;
      busy <= 1'h0;
      pd_drv <= 8'h5A;
      lo_cnt <= 0;
      last_w <= 0;
      dly <= 0;
    end else begin
      if (dly != 0) dly <= dly - 1;
      if (!dv_pin) lo_cnt <= lo_cnt + 1;
      if (!dv_pin && lo_cnt == 0) busy <= 1'h1;
      if (dv_pin && lo_cnt != 0) begin
        got.push_back(pd_pin);
        last_w <= lo_cnt;
        lo_cnt <= 0;
        dly <= 12;
      end
      if (kick) dly <= 4;
      ack_n <= !(dly >= 1 && dly <= 3);
      if (dly == 1) busy <= 1'h0;
    end
  end
endmodule // pport_printer_model
`default_nettype wire

//--- dv/fifo_parallel_printer_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_parallel_printer_port_bench;
  logic       mclk, rst, cs_n, wr_n, rd_n, kick, err_i, sel_i, pe_i, ack_n, busy, rpin;
  logic       doe_n, dtk, pd_oe_n, dv_o, dv_oe_n, lf_o, lf_oe_n, rs_o, rs_oe_n, ch_o, ch_oe_n;
  logic       irq, irq_oe_n;
  logic [2:0] addr;
  logic [7:0] din, dout, pd_out, pd_drv, q, r, seed;
  logic [7:0] exp_q[$];
  logic [7:0] wid[4] = '{8'h0A, 8'h14, 8'h32, 8'h64};
  int         bad_count, cmp_count, i, w;
  wire  [7:0] pd_w = pd_oe_n ? pd_drv : pd_out;
  wire        dv_w = dv_oe_n ? 1'h1 : dv_o;

  fifo_parallel_printer_port #(.FIFO_DEPTH(8)) u_dut (
    .mclk(mclk), .rst(rst), .reset_pin(rpin), .bus_mode(1'h1),
    .host_cs_n(cs_n), .host_addr(addr), .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_n(doe_n), .data_taken_out(dtk),
    .periph_data_lines_in(pd_w), .periph_data_lines_out(pd_out), .periph_data_lines_oe_n(pd_oe_n),
    .error_input(err_i), .periph_selected_input(sel_i), .paper_out_input(pe_i),
    .ack_input(ack_n), .busy_input(busy), .data_valid_in(dv_w), .data_valid_out(dv_o),
    .data_valid_oe_n(dv_oe_n), .line_feed_request_in(lf_oe_n | lf_o),
    .line_feed_request_out(lf_o), .line_feed_request_oe_n(lf_oe_n), .restart_in(rs_oe_n | rs_o),
    .restart_out(rs_o), .restart_oe_n(rs_oe_n), .periph_choose_in(ch_oe_n | ch_o),
    .periph_choose_out(ch_o), .periph_choose_oe_n(ch_oe_n), .interrupt_out(irq),
    .interrupt_oe_n(irq_oe_n));

  pport_printer_model u_prn (.mclk(mclk), .rst(rst), .dv_pin(dv_w), .pd_pin(pd_w), .kick(kick),
    .ack_n(ack_n), .busy(busy), .pd_drv(pd_drv));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe held two cycles, then a three-cycle gap before the next access
  task automatic bus(input logic wr1, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    cs_n <= 1'h0;
    addr <= a;
    din <= d;
    wr_n <= !wr1;
    rd_n <= wr1;
    repeat (2) @(posedge mclk);
    cs_n <= 1'h1;
    wr_n <= 1'h1;
    rd_n <= 1'h1;
    #1 q = dout;
    repeat (2) @(posedge mclk);
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    {rst, cs_n, wr_n, rd_n} = 4'hF;
    {rpin, kick, err_i, sel_i, pe_i, addr, din} = 0;
    seed = 8'h54;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    chk({7'h00, pd_oe_n}, 8'h00);
    bus(0, 3'h3, 8'h00);
    chk(q, 8'h00);
    bus(0, 3'h7, 8'h00);
    chk(q, 8'hFF);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r = seed & 8'h3E;
      bus(1, 3'h2, r);
      bus(0, 3'h2, 8'h00);
      chk(q, {3'h7, r[4:0]});
    end
    bus(1, 3'h2, 8'h04);
    seed = lfsr(seed);
    bus(1, 3'h0, seed);
    chk(pd_out, seed);
    bus(1, 3'h2, 8'h24);
    bus(0, 3'h0, 8'h00);
    chk(q, pd_drv);
    bus(1, 3'h2, 8'h04);
    $display("test pins done");
    bus(1, 3'h3, 8'h01);
    bus(1, 3'h0, 8'hC3);
    bus(1, 3'h0, 8'h3C);
    repeat (50) @(posedge mclk);
    chk(8'(u_prn.got.size()), 8'h00);
    bus(0, 3'h5, 8'h00);
    chk(q, 8'h05);
    bus(1, 3'h2, 8'h00);
    bus(1, 3'h2, 8'h04);
    bus(0, 3'h5, 8'h00);
    chk(q, 8'h01);
    $display("test restart done");
    kick <= 1'h1;
    @(posedge mclk);
    kick <= 1'h0;
    for (w = 0; w < 4; w++) begin
      seed = lfsr(seed);
      bus(1, 3'h3, 8'(w * 8 + 1));
      bus(1, 3'h0, seed);
      exp_q.push_back(seed);
      for (i = 0; i < 3000 && u_prn.got.size() <= w; i++) @(posedge mclk);
      // Let the model's width count settle past the edge
      #1;
      chk(u_prn.got[w], exp_q[w]);
      chk(8'(u_prn.last_w), wid[w]);
    end
    bus(1, 3'h3, 8'h01);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      bus(1, 3'h0, seed);
      exp_q.push_back(seed);
    end
    for (i = 0; i < 3000 && u_prn.got.size() < 7; i++) @(posedge mclk);
    for (i = 4; i < 7; i++) chk(u_prn.got[i], exp_q[i]);
    $display("test transfer done");
    repeat (20) @(posedge mclk);
    {err_i, sel_i, pe_i} <= seed[2:0];
    bus(1, 3'h2, 8'h14);
    chk({7'h00, irq}, 8'h00);
    bus(0, 3'h1, 8'h00);
    chk(q, {~busy, ack_n, pe_i, sel_i, err_i, 3'h3});
    chk({7'h00, irq}, 8'h01);
    bus(0, 3'h1, 8'h00);
    chk(q, {~busy, ack_n, pe_i, sel_i, err_i, 3'h7});
    bus(1, 3'h3, 8'h81);
    chk({7'h00, irq}, 8'h00);
    bus(1, 3'h3, 8'h83);
    chk({7'h00, irq}, 8'h01);
    bus(1, 3'h2, 8'h04);
    chk({7'h00, irq_oe_n}, 8'h01);
    rpin <= 1'h1;
    @(posedge mclk);
    rpin <= 1'h0;
    bus(0, 3'h3, 8'h00);
    chk(q, 8'h00);
    $display("test interrupt done");
    print_verdict();
  end
endmodule // fifo_parallel_printer_port_bench
`default_nettype wire
